// file: design/asdr_pkg.sv
// constants, field layout and carrier types of the status and data bank
// assumes a serial front end that presents byte reads and writes
package asdr_pkg;
	localparam logic [7:0] ADDR_PART_ID = 8'h00;
	localparam logic [7:0] ADDR_X_LOW = 8'h02;
	localparam logic [7:0] ADDR_X_HIGH = 8'h03;
	localparam logic [7:0] ADDR_Y_LOW = 8'h04;
	localparam logic [7:0] ADDR_Y_HIGH = 8'h05;
	localparam logic [7:0] ADDR_Z_LOW = 8'h06;
	localparam logic [7:0] ADDR_Z_HIGH = 8'h07;
	localparam logic [7:0] ADDR_MOTION_STS = 8'h09;
	localparam logic [7:0] ADDR_BUFFER_STS = 8'h0A;
	localparam logic [7:0] ADDR_SLOPE_DETAIL = 8'h0B;
	localparam logic [7:0] ADDR_FILL_STS = 8'h0C;
	localparam logic [7:0] ADDR_HOST_IF_CFG = 8'h34;
	localparam logic [7:0] ADDR_LOWPASS_CFG = 8'h35;
	localparam logic [7:0] ADDR_OFS_CTRL = 8'h36;
	localparam logic [7:0] ADDR_OFS_X = 8'h38;
	localparam logic [7:0] ADDR_BUF_LEVEL_CFG = 8'h3D;
	localparam logic [7:0] ADDR_BUF_OP_CFG = 8'h3E;
	localparam logic [7:0] ADDR_BUF_READ = 8'h3F;
	// writable field masks, reserved bits stay zero
	localparam logic [7:0] MASK_HOST_IF_CFG = 8'h07;
	localparam logic [7:0] MASK_LOWPASS_CFG = 8'h07;
	localparam logic [7:0] MASK_OFS_CTRL = 8'h80;
	localparam logic [7:0] MASK_BUF_LEVEL_CFG = 8'h7F;
	localparam logic [7:0] MASK_BUF_OP_CFG = 8'hEF;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam int BIT_SIG_MOTION = 0;
	localparam int BIT_SLOPE_MOTION = 2;
	localparam int BIT_BUF_FULL = 5;
	localparam int BIT_BUF_WM = 6;
	localparam int BIT_NEW_SAMPLE = 7;
	localparam int MODE_MSB = 7;
	localparam int MODE_LSB = 5;
	localparam logic [2:0] MODE_BYPASS = 3'h0;
	localparam logic [6:0] FULL_FRAMES = 7'h20;
	localparam logic [6:0] FULL_FRAMES_BYPASS = 7'h01;
	// arbitrary neutral identifier value
	localparam logic [7:0] PART_ID_VALUE = 8'hA5;

	typedef struct packed {
		logic [15:0] x;
		logic [15:0] y;
		logic [15:0] z;
	} asdr_sample_t;

	typedef struct packed {
		logic [2:0] sign;
		logic [2:0] cause;
	} asdr_slope_t;
endpackage : asdr_pkg

// file: design/asdr_bank.sv
// status, result and configuration register bank
// assumes the serial front end gives one-cycle read and write strobes
`timescale 1ns/10ps
module asdr_bank (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic sample_valid,
	input wire asdr_pkg::asdr_sample_t sample_in,
	input wire logic sig_motion_evt,
	input wire logic slope_evt,
	input wire asdr_pkg::asdr_slope_t slope_in,
	input wire logic new_sample_evt,
	input wire logic [6:0] buffer_count,
	input wire logic buffer_overrun_evt,
	input wire logic [7:0] buffer_read_byte,
	output logic buffer_pop,
	output logic buffer_flush,
	output logic [7:0] host_interface_config,
	output logic [7:0] lowpass_config,
	output logic [7:0] offset_comp_control,
	output logic [7:0] x_offset_trim,
	output logic [7:0] y_offset_trim,
	output logic [7:0] z_offset_trim,
	output logic [7:0] buffer_level_config,
	output logic [7:0] buffer_operation_config
);
	import asdr_pkg::*;

	function automatic logic is_buf_cfg(input logic [7:0] a);
		is_buf_cfg = (a == ADDR_BUF_LEVEL_CFG) || (a == ADDR_BUF_OP_CFG);
	endfunction : is_buf_cfg

	function automatic logic [7:0] low_or_high(input logic [15:0] w,
		input logic hi);
		low_or_high = hi ? w[15:8] : w[7:0];
	endfunction : low_or_high

	asdr_sample_t sample_q;
	logic significant_motion_flag;
	logic slope_motion_flag;
	logic buffer_full_flag;
	logic buffer_watermark_flag;
	logic new_sample_flag;
	asdr_slope_t slope_detail;
	logic buffer_overrun_flag;
	logic [6:0] unread_frame_count;
	logic [7:0] offset_trim [3];
	logic full_cond;
	logic full_cond_q;
	logic wm_cond;
	logic wm_cond_q;
	logic buf_cfg_wr;
	logic rd_motion;
	logic rd_buffer_sts;
	logic rd_port;
	logic [7:0] next_rdata;
	logic [7:0] motion_status;
	logic [7:0] buffer_event_status;

	assign buf_cfg_wr = reg_wr && is_buf_cfg(reg_addr);
	assign rd_motion = reg_rd && (reg_addr == ADDR_MOTION_STS);
	assign rd_buffer_sts = reg_rd && (reg_addr == ADDR_BUFFER_STS);
	assign rd_port = reg_rd && (reg_addr == ADDR_BUF_READ);
	assign motion_status = {5'h00, slope_motion_flag, 1'b0,
		significant_motion_flag};
	assign buffer_event_status = {new_sample_flag, buffer_watermark_flag,
		buffer_full_flag, 5'h00};

	////////////////////////////////////////////////////////////////////////
	// axis results, updated as a whole word set so bytes stay coherent
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sample_q <= '0;
		end else if (sample_valid) begin
			sample_q <= sample_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// motion and sample flags: sticky, cleared by reading their register,
	// an event in the clearing cycle wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			significant_motion_flag <= 1'b0;
			slope_motion_flag <= 1'b0;
			new_sample_flag <= 1'b0;
		end else begin
			if (sig_motion_evt) begin
				significant_motion_flag <= 1'b1;
			end else if (rd_motion) begin
				significant_motion_flag <= 1'b0;
			end
			if (slope_evt) begin
				slope_motion_flag <= 1'b1;
			end else if (rd_motion) begin
				slope_motion_flag <= 1'b0;
			end
			if (new_sample_evt) begin
				new_sample_flag <= 1'b1;
			end else if (rd_buffer_sts) begin
				new_sample_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			slope_detail <= '0;
		end else if (slope_evt) begin
			slope_detail <= slope_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// buffer full and watermark: set on the rising condition only, so a
	// stale count during a flush cannot re-arm them
	always_comb begin
		if (buffer_operation_config[MODE_MSB:MODE_LSB] == MODE_BYPASS) begin
			full_cond = (buffer_count >= FULL_FRAMES_BYPASS);
		end else begin
			full_cond = (buffer_count >= FULL_FRAMES);
		end
		wm_cond = (buffer_level_config[6:0] != 7'h00) &&
			(buffer_count >= buffer_level_config[6:0]);
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			full_cond_q <= 1'b0;
			wm_cond_q <= 1'b0;
			buffer_full_flag <= 1'b0;
			buffer_watermark_flag <= 1'b0;
		end else begin
			full_cond_q <= full_cond;
			wm_cond_q <= wm_cond;
			if (full_cond && !full_cond_q) begin
				buffer_full_flag <= 1'b1;
			end else if (buf_cfg_wr) begin
				buffer_full_flag <= 1'b0;
			end
			if (wm_cond && !wm_cond_q) begin
				buffer_watermark_flag <= 1'b1;
			end else if (buf_cfg_wr) begin
				buffer_watermark_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			buffer_overrun_flag <= 1'b0;
			unread_frame_count <= 7'h00;
		end else begin
			unread_frame_count <= buffer_count;
			if (buffer_overrun_evt) begin
				buffer_overrun_flag <= 1'b1;
			end else if (rd_port) begin
				buffer_overrun_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			buffer_pop <= 1'b0;
			buffer_flush <= 1'b0;
		end else begin
			buffer_pop <= rd_port;
			buffer_flush <= buf_cfg_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// writable configuration, reserved bits masked off
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			host_interface_config <= CFG_RESET;
			lowpass_config <= CFG_RESET;
			offset_comp_control <= CFG_RESET;
			buffer_level_config <= CFG_RESET;
			buffer_operation_config <= CFG_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
			ADDR_HOST_IF_CFG: host_interface_config <= reg_wdata &
				MASK_HOST_IF_CFG;
			ADDR_LOWPASS_CFG: lowpass_config <= reg_wdata &
				MASK_LOWPASS_CFG;
			ADDR_OFS_CTRL: offset_comp_control <= reg_wdata & MASK_OFS_CTRL;
			ADDR_BUF_LEVEL_CFG: buffer_level_config <= reg_wdata &
				MASK_BUF_LEVEL_CFG;
			ADDR_BUF_OP_CFG: buffer_operation_config <= reg_wdata &
				MASK_BUF_OP_CFG;
			default: ;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gen_trim
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					offset_trim[g] <= CFG_RESET;
				end else if (reg_wr && (reg_addr == ADDR_OFS_X + 8'(g))) begin
					offset_trim[g] <= reg_wdata;
				end
			end
		end
	endgenerate

	assign x_offset_trim = offset_trim[0];
	assign y_offset_trim = offset_trim[1];
	assign z_offset_trim = offset_trim[2];

	////////////////////////////////////////////////////////////////////////
	// read path, one cycle latency; status shown before its clear
	always_comb begin
		case (reg_addr)
		ADDR_PART_ID: next_rdata = PART_ID_VALUE;
		ADDR_X_LOW: next_rdata = low_or_high(sample_q.x, 1'b0);
		ADDR_X_HIGH: next_rdata = low_or_high(sample_q.x, 1'b1);
		ADDR_Y_LOW: next_rdata = low_or_high(sample_q.y, 1'b0);
		ADDR_Y_HIGH: next_rdata = low_or_high(sample_q.y, 1'b1);
		ADDR_Z_LOW: next_rdata = low_or_high(sample_q.z, 1'b0);
		ADDR_Z_HIGH: next_rdata = low_or_high(sample_q.z, 1'b1);
		ADDR_MOTION_STS: next_rdata = motion_status;
		ADDR_BUFFER_STS: next_rdata = buffer_event_status;
		ADDR_SLOPE_DETAIL: next_rdata = {1'b0, slope_detail.sign, 1'b0,
			slope_detail.cause};
		ADDR_FILL_STS: next_rdata = {buffer_overrun_flag,
			unread_frame_count};
		ADDR_HOST_IF_CFG: next_rdata = host_interface_config;
		ADDR_LOWPASS_CFG: next_rdata = lowpass_config;
		ADDR_OFS_CTRL: next_rdata = offset_comp_control;
		ADDR_OFS_X: next_rdata = offset_trim[0];
		ADDR_OFS_X + 8'h01: next_rdata = offset_trim[1];
		ADDR_OFS_X + 8'h02: next_rdata = offset_trim[2];
		ADDR_BUF_LEVEL_CFG: next_rdata = buffer_level_config;
		ADDR_BUF_OP_CFG: next_rdata = buffer_operation_config;
		ADDR_BUF_READ: next_rdata = buffer_read_byte;
		default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_sig_motion;
		@(posedge mclk) disable iff (!rst_n)
		sig_motion_evt |=> motion_status[BIT_SIG_MOTION];
	endproperty
	a_sig_motion: assert property (p_sig_motion)
		else $error("significant motion flag not set");

	property p_slope_motion;
		@(posedge mclk) disable iff (!rst_n)
		slope_evt |=> motion_status[BIT_SLOPE_MOTION];
	endproperty
	a_slope_motion: assert property (p_slope_motion)
		else $error("slope flag not set");

	property p_full;
		@(posedge mclk) disable iff (!rst_n)
		$rose(full_cond) |=> buffer_event_status[BIT_BUF_FULL];
	endproperty
	a_full: assert property (p_full)
		else $error("full flag missed");

	property p_watermark;
		@(posedge mclk) disable iff (!rst_n)
		(wm_cond && !wm_cond_q) |=> buffer_event_status[BIT_BUF_WM];
	endproperty
	a_watermark: assert property (p_watermark)
		else $error("watermark flag missed");

	property p_new_sample;
		@(posedge mclk) disable iff (!rst_n)
		new_sample_evt |=> buffer_event_status[BIT_NEW_SAMPLE];
	endproperty
	a_new_sample: assert property (p_new_sample)
		else $error("new sample flag not set");

	property p_detail;
		@(posedge mclk) disable iff (!rst_n)
		slope_evt |=> slope_detail == $past(slope_in);
	endproperty
	a_detail: assert property (p_detail)
		else $error("slope detail not captured");

	property p_x_high;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_X_HIGH && !sample_valid)
		|=> reg_rdata == sample_q.x[15:8];
	endproperty
	a_x_high: assert property (p_x_high)
		else $error("x high byte wrong");

	property p_part_id;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_PART_ID) |=> reg_rdata == PART_ID_VALUE;
	endproperty
	a_part_id: assert property (p_part_id)
		else $error("part identifier wrong");

	property p_motion_reserved;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == ADDR_MOTION_STS)
		|=> (reg_rdata & 8'hFA) == 8'h00;
	endproperty
	a_motion_reserved: assert property (p_motion_reserved)
		else $error("motion status reserved bits set");

	property p_overrun_clear;
		@(posedge mclk) disable iff (!rst_n)
		(rd_port && !buffer_overrun_evt) |=> !buffer_overrun_flag;
	endproperty
	a_overrun_clear: assert property (p_overrun_clear)
		else $error("overrun flag not cleared");

	property p_cfg_clear;
		@(posedge mclk) disable iff (!rst_n)
		(buf_cfg_wr && !(full_cond && !full_cond_q))
		|=> buffer_flush && !buffer_full_flag;
	endproperty
	a_cfg_clear: assert property (p_cfg_clear)
		else $error("config write did not flush");

	property p_unmapped;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && (reg_addr == 8'h01 || reg_addr == 8'h37 ||
		reg_addr == 8'h3B)) |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("reserved address not zero");
endmodule : asdr_bank

// file: bench/asdr_host.sv
// host model: issues single byte register reads and writes to the bank
// assumes strobes are taken on the rising edge of mclk
`timescale 1ns/10ps
module asdr_host (
	input wire logic mclk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// idle lines carry the inverse so a stale value never looks valid
	task automatic release_bus();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask : release_bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1;
		release_bus();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(posedge mclk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1;
		release_bus();
		v = reg_rvalid;
		d = reg_rdata;
	endtask : rd
endmodule : asdr_host

// file: bench/asdr_bank_tb.sv
// self-checking bench for the status, result and configuration bank
// assumes asdr_pkg and asdr_bank are compiled first
`timescale 1ns/10ps
module asdr_bank_tb;
	import asdr_pkg::*;
	logic mclk, rst_n, reg_wr, reg_rd, reg_rvalid, sample_valid;
	logic sig_motion_evt, slope_evt, new_sample_evt, buffer_overrun_evt;
	logic buffer_pop, buffer_flush;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, buffer_read_byte;
	logic [7:0] cfg_if, cfg_lp, cfg_oc, cfg_ox, cfg_oy, cfg_oz;
	logic [7:0] cfg_lv, cfg_op;
	logic [6:0] buffer_count;
	asdr_sample_t sample_in;
	asdr_slope_t slope_in;
	int fail_count = 0;
	int checks_done = 0;
	logic [7:0] cfg_a [8] = '{8'h34, 8'h35, 8'h36, 8'h38, 8'h39, 8'h3A,
		8'h3D, 8'h3E};
	logic [7:0] cfg_m [8] = '{MASK_HOST_IF_CFG, MASK_LOWPASS_CFG,
		MASK_OFS_CTRL, 8'hFF, 8'hFF, 8'hFF, MASK_BUF_LEVEL_CFG,
		MASK_BUF_OP_CFG};
	logic [7:0] res_e [6] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'hBC, 8'h9A};

	asdr_bank u_asdr_bank (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.sample_valid(sample_valid), .sample_in(sample_in),
		.sig_motion_evt(sig_motion_evt), .slope_evt(slope_evt),
		.slope_in(slope_in), .new_sample_evt(new_sample_evt),
		.buffer_count(buffer_count), .buffer_overrun_evt(buffer_overrun_evt),
		.buffer_read_byte(buffer_read_byte), .buffer_pop(buffer_pop),
		.buffer_flush(buffer_flush), .host_interface_config(cfg_if),
		.lowpass_config(cfg_lp), .offset_comp_control(cfg_oc),
		.x_offset_trim(cfg_ox), .y_offset_trim(cfg_oy),
		.z_offset_trim(cfg_oz), .buffer_level_config(cfg_lv),
		.buffer_operation_config(cfg_op));
	asdr_host u_asdr_host (.mclk(mclk), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		u_asdr_host.rd(a, d, v);
		chk("rvalid", {7'h00, v}, 8'h01);
		chk($sformatf("reg %h", a), d, e);
	endtask : rchk
	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 64; i++) begin
			rchk(i[7:0], (i == 0) ? PART_ID_VALUE : 8'h00);
		end
	endtask : t_reset
	task automatic t_config();
		for (int i = 0; i < 8; i++) begin
			u_asdr_host.wr(cfg_a[i], 8'hFF);
			rchk(cfg_a[i], cfg_m[i]);
		end
		chk("level cfg", cfg_lv, MASK_BUF_LEVEL_CFG);
		chk("op cfg", cfg_op, MASK_BUF_OP_CFG);
		chk("if cfg", cfg_if, MASK_HOST_IF_CFG);
		chk("lowpass cfg", cfg_lp, MASK_LOWPASS_CFG);
		chk("ofs ctrl", cfg_oc, MASK_OFS_CTRL);
		chk("x trim", cfg_ox, 8'hFF);
		chk("y trim", cfg_oy, 8'hFF);
		chk("z trim", cfg_oz, 8'hFF);
		u_asdr_host.wr(8'h37, 8'hFF);
		rchk(8'h37, 8'h00);
	endtask : t_config
	task automatic t_results();
		sample_in = {16'h1234, 16'h5678, 16'h9ABC};
		sample_valid = 1'b1;
		tick();
		sample_valid = 1'b0;
		u_asdr_host.wr(ADDR_X_LOW, 8'hFF);
		for (int i = 0; i < 6; i++) begin
			rchk(ADDR_X_LOW + i[7:0], res_e[i]);
		end
	endtask : t_results
	task automatic t_events();
		slope_in = {3'b101, 3'b010};
		sig_motion_evt = 1'b1;
		slope_evt = 1'b1;
		new_sample_evt = 1'b1;
		tick();
		sig_motion_evt = 1'b0;
		slope_evt = 1'b0;
		new_sample_evt = 1'b0;
		u_asdr_host.wr(ADDR_MOTION_STS, 8'hFF);
		rchk(ADDR_MOTION_STS, 8'h05);
		rchk(ADDR_MOTION_STS, 8'h00);
		rchk(ADDR_SLOPE_DETAIL, 8'h52);
		rchk(ADDR_BUFFER_STS, 8'h80);
		slope_in = {3'b000, 3'b001};
		slope_evt = 1'b1;
		tick();
		slope_evt = 1'b0;
		rchk(ADDR_MOTION_STS, 8'h04);
		rchk(ADDR_SLOPE_DETAIL, 8'h01);
	endtask : t_events
	task automatic t_fifo();
		u_asdr_host.wr(ADDR_BUF_OP_CFG, 8'h20);
		chk("flush", {7'h00, buffer_flush}, 8'h01);
		u_asdr_host.wr(ADDR_BUF_LEVEL_CFG, 8'h05);
		buffer_count = 7'h04;
		rchk(ADDR_BUFFER_STS, 8'h00);
		buffer_count = 7'h05;
		rchk(ADDR_BUFFER_STS, 8'h40);
		buffer_count = 7'h1F;
		rchk(ADDR_BUFFER_STS, 8'h40);
		buffer_count = 7'h20;
		rchk(ADDR_BUFFER_STS, 8'h60);
		rchk(ADDR_FILL_STS, 8'h20);
		buffer_overrun_evt = 1'b1;
		tick();
		buffer_overrun_evt = 1'b0;
		rchk(ADDR_FILL_STS, 8'hA0);
		buffer_read_byte = 8'h5A;
		rchk(ADDR_BUF_READ, 8'h5A);
		chk("pop", {7'h00, buffer_pop}, 8'h01);
		rchk(ADDR_FILL_STS, 8'h20);
		u_asdr_host.wr(ADDR_BUF_LEVEL_CFG, 8'h05);
		buffer_count = 7'h00;
		chk("flush", {7'h00, buffer_flush}, 8'h01);
		rchk(ADDR_BUFFER_STS, 8'h00);
		rchk(ADDR_FILL_STS, 8'h00);
		// bypass holds a single frame
		u_asdr_host.wr(ADDR_BUF_OP_CFG, 8'h00);
		buffer_count = 7'h01;
		rchk(ADDR_BUFFER_STS, 8'h20);
	endtask : t_fifo
	task automatic t_rerun();
		// a flag and a result held before a mid-run reset must not survive
		buffer_count = 7'h00;
		sig_motion_evt = 1'b1;
		tick();
		sig_motion_evt = 1'b0;
		rst_n = 1'b0;
		tick();
		rst_n = 1'b1;
		rchk(ADDR_MOTION_STS, 8'h00);
		rchk(ADDR_X_HIGH, 8'h00);
		rchk(ADDR_FILL_STS, 8'h00);
	endtask : t_rerun
	////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		#40000;
		fail_count++;
		end_sim();
	end
	initial begin
		rst_n = 1'b0;
		sample_valid = 1'b0;
		sample_in = '0;
		sig_motion_evt = 1'b0;
		slope_evt = 1'b0;
		slope_in = '0;
		new_sample_evt = 1'b0;
		buffer_count = 7'h00;
		buffer_overrun_evt = 1'b0;
		buffer_read_byte = 8'h00;
		repeat (5) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		t_reset();
		t_config();
		t_results();
		t_events();
		t_fifo();
		t_rerun();
		end_sim();
	end
endmodule : asdr_bank_tb
